// file: design/adc_status_pkg.sv
// Purpose: shared constants for the converter status flag block
// Assumes: 8-bit registers on a 32-bit APB word, one word per register
// Notes:   byte address of a register is four times its index
package adc_status_pkg;
	localparam int REG_WIDTH                  = 8;
	localparam int REG_INDEX_CONTROL_ZERO     = 0;
	localparam int REG_INDEX_CONTROL_ONE      = 1;
	localparam int REG_INDEX_CONTROL_TWO      = 2;
	localparam int REG_INDEX_CONTROL_THREE    = 3;
	localparam int REG_INDEX_CONTROL_FOUR     = 4;
	localparam int REG_INDEX_SEQUENCE_START   = 5;
	localparam int REG_INDEX_STATUS_ZERO      = 6;
	localparam int REG_INDEX_COMPARE_ENABLE   = 8;
	localparam int REG_INDEX_COMPARE_DIRECT   = 9;
	localparam int REG_INDEX_IRQ_STATUS       = 10;
	localparam int REG_INDEX_IRQ_MASK         = 11;
	localparam int CONTROL_COUNT              = 5;
	localparam int BIT_SEQUENCE_FINISHED      = 7;
	localparam int BIT_TRIGGER_OVERRUN        = 5;
	localparam int BIT_RESULT_OVERRUN         = 4;
	localparam int COUNTER_LSB                = 0;
	localparam int COUNTER_WIDTH              = 4;
	localparam int BIT_TRIGGER_LEVEL_SELECT   = 0;
	localparam int BIT_FAST_FLAG_CLEAR        = 0;
	localparam int BIT_SCAN                   = 0;
	localparam int EVT_SEQUENCE_FINISHED      = 0;
	localparam int EVT_TRIGGER_OVERRUN        = 1;
	localparam int EVT_RESULT_OVERRUN         = 2;
	localparam int EVT_COUNT                  = 3;
	localparam logic [7:0] CONTROL_RESET      = 8'h00;
	localparam logic [7:0] MASK_RESET         = 8'h00;
	localparam logic [3:0] COUNTER_RESET      = 4'h0;
	typedef enum logic [0:0] {seq_idle, seq_running} seq_state_t;
endpackage

// file: design/sticky_flags.sv
// Purpose: bank of sticky flags, set by hardware, cleared by request
// Assumes: set and clear are one-cycle qualified strobes
// Notes:   a set in the clear cycle survives
`timescale 1ns/1ps
`default_nettype none
module sticky_flags #(
	parameter int WIDTH = 3
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] set,
	input  wire logic [WIDTH-1:0] clear,
	output logic      [WIDTH-1:0] flags
);
	if (WIDTH < 1) begin : g_check
		$error("sticky_flags needs WIDTH of at least 1");
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			flags <= '0;
		end else begin
			// set is applied last so a coincident event is not lost
			flags <= (flags & ~clear) | set;
		end
	end
endmodule
`default_nettype wire

// file: design/adc_sequence_status.sv
// Purpose: status flags and conversion counter of a converter sequencer
// Assumes: APB slave, 40 MHz clk, event inputs synchronous one-cycle pulses
// Notes:   zero wait states; read data is captured in the setup cycle
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module adc_sequence_status
	import adc_status_pkg::*;
#(
	parameter int ADDR_WIDTH = 8
) (
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [ADDR_WIDTH-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  sequence_done,
	input  wire logic                  trigger_edge,
	input  wire logic                  result_write,
	input  wire logic                  result_write_ccf_set,
	input  wire logic                  result_read,
	output logic                       sequence_start_pulse,
	output logic                       sequence_abort_pulse,
	output logic                       sequence_running,
	output logic                       scan_mode,
	output logic                       trigger_level_select,
	output logic                       fast_flag_clear_enable,
	output logic                       irq
);
	localparam int IW = ADDR_WIDTH - 2;

	if (ADDR_WIDTH < 6 || ADDR_WIDTH > 32) begin : g_check
		$error("ADDR_WIDTH must be 6..32 to reach every register");
	end

	logic [IW-1:0]            word_index;
	logic                     word_aligned;
	logic                     mapped;
	logic                     setup_phase;
	logic                     access_done;
	logic                     wr;
	logic [REG_WIDTH-1:0]     wbyte;
	logic [REG_WIDTH-1:0]     control_regs [CONTROL_COUNT];
	logic [REG_WIDTH-1:0]     compare_enable_register;
	logic [REG_WIDTH-1:0]     compare_direction_register;
	logic [REG_WIDTH-1:0]     sequence_start_control;
	logic [REG_WIDTH-1:0]     irq_mask;
	logic [EVT_COUNT-1:0]     irq_flags;
	logic [COUNTER_WIDTH-1:0] conversion_counter;
	logic [REG_WIDTH-1:0]     converter_status_zero;
	logic [REG_WIDTH-1:0]     read_byte;
	logic                     wr_control;
	logic                     wr_start;
	logic                     wr_status;
	logic                     wr_compare;
	logic                     wr_irq_status;
	logic                     wr_abort;
	logic                     sequence_finished_flag;
	logic                     trigger_overrun_flag;
	logic                     result_overrun_flag;
	logic [EVT_COUNT-1:0]     flag_set;
	logic [EVT_COUNT-1:0]     flag_clear;
	logic [EVT_COUNT-1:0]     status_flags;
	logic [EVT_COUNT-1:0]     irq_clear;
	seq_state_t               seq_state;
	seq_state_t               next_seq_state;

	// bus decode
	assign word_index   = paddr[ADDR_WIDTH-1:2];
	assign word_aligned = (paddr[1:0] == 2'b00);
	assign setup_phase  = psel && !penable;
	assign access_done  = psel && penable && pready;
	assign wbyte        = pwdata[REG_WIDTH-1:0];

	always_comb begin
		mapped = 1'b0;
		if (word_aligned) begin
			case (word_index)
				IW'(REG_INDEX_CONTROL_ZERO),
				IW'(REG_INDEX_CONTROL_ONE),
				IW'(REG_INDEX_CONTROL_TWO),
				IW'(REG_INDEX_CONTROL_THREE),
				IW'(REG_INDEX_CONTROL_FOUR),
				IW'(REG_INDEX_SEQUENCE_START),
				IW'(REG_INDEX_STATUS_ZERO),
				IW'(REG_INDEX_COMPARE_ENABLE),
				IW'(REG_INDEX_COMPARE_DIRECT),
				IW'(REG_INDEX_IRQ_STATUS),
				IW'(REG_INDEX_IRQ_MASK): begin
					mapped = 1'b1;
				end
				default: begin
					mapped = 1'b0;
				end
			endcase
		end
	end

	// a write lands only in the completing access cycle, low lane enabled
	assign wr = access_done && pwrite && mapped && pstrb[0];

	assign wr_control    = wr && (word_index <= IW'(REG_INDEX_CONTROL_FOUR));
	assign wr_start      = wr && (word_index == IW'(REG_INDEX_SEQUENCE_START));
	assign wr_status     = wr && (word_index == IW'(REG_INDEX_STATUS_ZERO));
	assign wr_irq_status = wr && (word_index == IW'(REG_INDEX_IRQ_STATUS));
	assign wr_compare    = wr && ((word_index == IW'(REG_INDEX_COMPARE_ENABLE))
		|| (word_index == IW'(REG_INDEX_COMPARE_DIRECT)));
	assign wr_abort      = wr_control || wr_compare;

	// answer: pready rises for the access cycle, so no wait states
	always_ff @(posedge clk) begin
		if (reset) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup_phase;
			pslverr <= setup_phase && !mapped;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			prdata <= '0;
		end else if (setup_phase && !pwrite && mapped) begin
			prdata <= {{(32 - REG_WIDTH){1'b0}}, read_byte};
		end else begin
			prdata <= '0;
		end
	end

	// status word: flags and counter side by side
	always_comb begin
		converter_status_zero = '0;
		converter_status_zero[BIT_SEQUENCE_FINISHED] = sequence_finished_flag;
		converter_status_zero[BIT_TRIGGER_OVERRUN]   = trigger_overrun_flag;
		converter_status_zero[BIT_RESULT_OVERRUN]    = result_overrun_flag;
		converter_status_zero[COUNTER_LSB +: COUNTER_WIDTH] = conversion_counter;
	end

	always_comb begin
		read_byte = '0;
		case (word_index)
			IW'(REG_INDEX_CONTROL_ZERO):   read_byte = control_regs[0];
			IW'(REG_INDEX_CONTROL_ONE):    read_byte = control_regs[1];
			IW'(REG_INDEX_CONTROL_TWO):    read_byte = control_regs[2];
			IW'(REG_INDEX_CONTROL_THREE):  read_byte = control_regs[3];
			IW'(REG_INDEX_CONTROL_FOUR):   read_byte = control_regs[4];
			IW'(REG_INDEX_SEQUENCE_START): read_byte = sequence_start_control;
			IW'(REG_INDEX_STATUS_ZERO):    read_byte = converter_status_zero;
			IW'(REG_INDEX_COMPARE_ENABLE): read_byte = compare_enable_register;
			IW'(REG_INDEX_COMPARE_DIRECT): read_byte = compare_direction_register;
			IW'(REG_INDEX_IRQ_STATUS): begin
				read_byte[EVT_COUNT-1:0] = irq_flags;
			end
			IW'(REG_INDEX_IRQ_MASK):       read_byte = irq_mask;
			default:                       read_byte = '0;
		endcase
	end

	// control storage; only control_regs 1 and 2 steer modes (trigger level select, fast flag clear)
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < CONTROL_COUNT; i++) begin
				control_regs[i] <= CONTROL_RESET;
			end
		end else if (wr_control) begin
			for (int i = 0; i < CONTROL_COUNT; i++) begin
				if (word_index == IW'(i)) begin
					control_regs[i] <= wbyte;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			compare_enable_register    <= CONTROL_RESET;
			compare_direction_register <= CONTROL_RESET;
		end else if (wr_compare) begin
			if (word_index == IW'(REG_INDEX_COMPARE_ENABLE)) begin
				compare_enable_register <= wbyte;
			end else begin
				compare_direction_register <= wbyte;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			sequence_start_control <= CONTROL_RESET;
		end else if (wr_start) begin
			sequence_start_control <= wbyte;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			irq_mask <= MASK_RESET;
		end else if (wr && word_index == IW'(REG_INDEX_IRQ_MASK)) begin
			irq_mask <= wbyte;
		end
	end

	// registered copies of the mode bits for the conversion engine
	always_ff @(posedge clk) begin
		if (reset) begin
			scan_mode              <= 1'b0;
			trigger_level_select   <= 1'b0;
			fast_flag_clear_enable <= 1'b0;
		end else begin
			scan_mode              <= sequence_start_control[BIT_SCAN];
			trigger_level_select   <= control_regs[1][BIT_TRIGGER_LEVEL_SELECT];
			fast_flag_clear_enable <= control_regs[2][BIT_FAST_FLAG_CLEAR];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			sequence_start_pulse <= 1'b0;
			sequence_abort_pulse <= 1'b0;
		end else begin
			sequence_start_pulse <= wr_start;
			sequence_abort_pulse <= wr_abort;
		end
	end

	// sequence tracker; an idle trigger edge starts a sequence
	always_comb begin
		next_seq_state = seq_state;
		case (seq_state)
			seq_idle: begin
				if (wr_start || trigger_edge) begin
					next_seq_state = seq_running;
				end
			end
			seq_running: begin
				if (wr_abort) begin
					next_seq_state = seq_idle;
				end else if (wr_start) begin
					next_seq_state = seq_running;
				end else if (sequence_done && !scan_mode) begin
					next_seq_state = seq_idle;
				end
			end
			default: begin
				next_seq_state = seq_idle;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			seq_state        <= seq_idle;
			sequence_running <= 1'b0;
		end else begin
			seq_state        <= next_seq_state;
			sequence_running <= (next_seq_state == seq_running);
		end
	end

	// counts results within a sequence; restarts on start or abort
	always_ff @(posedge clk) begin
		if (reset) begin
			conversion_counter <= COUNTER_RESET;
		end else if (wr_start || wr_abort) begin
			conversion_counter <= COUNTER_RESET;
		end else if (result_write) begin
			conversion_counter <= conversion_counter + COUNTER_WIDTH'(1);
		end
	end

	// flag events
	always_comb begin
		flag_set = '0;
		// every completion sets, so scan mode re-flags each pass
		flag_set[EVT_SEQUENCE_FINISHED] = sequence_done;
		flag_set[EVT_TRIGGER_OVERRUN]   = trigger_edge && (seq_state == seq_running)
			&& !trigger_level_select;
		flag_set[EVT_RESULT_OVERRUN]    = result_write && result_write_ccf_set;
	end

	// clears: in a status write only ones act, zeros leave a flag alone; start, abort and fast clear act regardless of data
	always_comb begin
		flag_clear = '0;
		if (wr_status) begin
			flag_clear[EVT_SEQUENCE_FINISHED] = wbyte[BIT_SEQUENCE_FINISHED];
			flag_clear[EVT_TRIGGER_OVERRUN]   = wbyte[BIT_TRIGGER_OVERRUN];
			flag_clear[EVT_RESULT_OVERRUN]    = wbyte[BIT_RESULT_OVERRUN];
		end
		if (wr_start) begin
			flag_clear = '1;
		end
		if (wr_abort) begin
			flag_clear[EVT_TRIGGER_OVERRUN] = 1'b1;
			flag_clear[EVT_RESULT_OVERRUN]  = 1'b1;
		end
		if (fast_flag_clear_enable && result_read) begin
			flag_clear[EVT_SEQUENCE_FINISHED] = 1'b1;
		end
	end

	sticky_flags #(
		.WIDTH (EVT_COUNT)
	) u_status_flags (
		.clk   (clk),
		.reset (reset),
		.set   (flag_set),
		.clear (flag_clear),
		.flags (status_flags)
	);

	assign sequence_finished_flag = status_flags[EVT_SEQUENCE_FINISHED];
	assign trigger_overrun_flag   = status_flags[EVT_TRIGGER_OVERRUN];
	assign result_overrun_flag    = status_flags[EVT_RESULT_OVERRUN];

	// interrupt bank keeps its own copy so status clears do not lose irqs
	assign irq_clear = wr_irq_status ? wbyte[EVT_COUNT-1:0] : '0;

	sticky_flags #(
		.WIDTH (EVT_COUNT)
	) u_irq_flags (
		.clk   (clk),
		.reset (reset),
		.set   (flag_set),
		.clear (irq_clear),
		.flags (irq_flags)
	);

	always_ff @(posedge clk) begin
		if (reset) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_flags & irq_mask[EVT_COUNT-1:0]);
		end
	end
endmodule
`default_nettype wire

// file: verif/adc_sequence_status_chk.sv
// Purpose: port assertions for the converter status flag block
// Assumes: zero wait APB answers, registered pulse outputs
// Notes:   status sits at byte address 0x18, index 7 unmapped
`timescale 1ns/1ps
`default_nettype none
module adc_sequence_status_chk #(
	parameter int ADDR_WIDTH = 8
) (
	input wire logic                  clk,
	input wire logic                  reset,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [ADDR_WIDTH-1:0] paddr,
	input wire logic [3:0]            pstrb,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire logic                  trigger_edge,
	input wire logic                  sequence_start_pulse,
	input wire logic                  sequence_abort_pulse,
	input wire logic                  sequence_running
);
	logic acc_wr;
	logic start_wr;
	logic abort_wr;
	logic bad_addr;
	assign acc_wr = psel && penable && pwrite && pready && pstrb[0];
	assign start_wr = acc_wr && paddr == ADDR_WIDTH'('h14);
	assign abort_wr = acc_wr && (paddr <= ADDR_WIDTH'('h10) || paddr == ADDR_WIDTH'('h20)
		|| paddr == ADDR_WIDTH'('h24)) && paddr[1:0] == 2'b00;
	assign bad_addr = paddr[1:0] != 2'b00 || paddr == ADDR_WIDTH'('h1c) || paddr > ADDR_WIDTH'('h2c);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	AST_READY_ONLY_ACCESS: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	AST_UNMAPPED_ERR: assert property (psel && penable && bad_addr |-> pslverr)
		else $error("unmapped access not refused");
	AST_MAPPED_OK: assert property (psel && penable && !bad_addr |-> !pslverr)
		else $error("mapped access refused");
	AST_UPPER_ZERO: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	AST_START_PULSE: assert property (start_wr |=>
		sequence_start_pulse && !sequence_abort_pulse)
		else $error("start write gave no start pulse");
	AST_START_RUNS: assert property (start_wr |-> ##[1:2] sequence_running)
		else $error("start write did not run");
	AST_PULSE_CAUSE: assert property (sequence_start_pulse |-> $past(start_wr))
		else $error("start pulse without write");
	AST_ABORT_PULSE: assert property (abort_wr |=>
		sequence_abort_pulse ##1 !sequence_abort_pulse)
		else $error("abort pulse wrong");
	AST_ABORT_STOPS: assert property (sequence_abort_pulse &&
		!$past(trigger_edge) |-> !sequence_running)
		else $error("abort left sequence running");
	cover property (start_wr);
	cover property (abort_wr);
	cover property (psel && penable && bad_addr);
	cover property (sequence_running && trigger_edge);
endmodule
bind adc_sequence_status adc_sequence_status_chk #(.ADDR_WIDTH(ADDR_WIDTH)) chk_u (.clk(clk),
	.reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pstrb(pstrb),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .trigger_edge(trigger_edge),
	.sequence_start_pulse(sequence_start_pulse), .sequence_abort_pulse(sequence_abort_pulse),
	.sequence_running(sequence_running));
`default_nettype wire

// file: verif/adc_sequence_status_test.sv
// Purpose: self-checking bench for the converter status flag block
// Assumes: zero wait APB, event inputs as one-cycle pulses
// Notes:   random values from an xorshift seeded with 69
`timescale 1ns/1ps
`default_nettype none
module adc_sequence_status_test;
	import adc_status_pkg::*;
	logic        clk, reset, psel, penable, pwrite, pready, pslverr, irq, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, rnd;
	logic [3:0]  pstrb;
	logic        sequence_done, trigger_edge, result_write, result_write_ccf_set, result_read;
	logic        sequence_running, scan_mode, level_sel, fast_clr;
	int          miscompares, checked, cycles, n;
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	adc_sequence_status dut_u (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sequence_done(sequence_done),
		.trigger_edge(trigger_edge), .result_write(result_write),
		.result_write_ccf_set(result_write_ccf_set), .result_read(result_read),
		.sequence_start_pulse(), .sequence_abort_pulse(), .sequence_running(sequence_running),
		.scan_mode(scan_mode), .trigger_level_select(level_sel),
		.fast_flag_clear_enable(fast_clr), .irq(irq));
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic logic [31:0] status_of(input bit fin, input bit tov, input bit rov,
		input int cnt);
		return {24'h0, fin, 1'b0, tov, rov, 4'(cnt)};
	endfunction
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// request held until pready is sampled high, then released
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge so a following call never re-drives psel in this step
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask
	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(a, 1'b0, 32'h0);
		check(what, exp, rd);
	endtask
	// 0 done, 1 trigger, 2 result with flag set, 3 plain result, 4 result read
	task automatic ev(input int k);
		sequence_done <= (k == 0);
		trigger_edge <= (k == 1);
		result_write <= (k == 2 || k == 3);
		result_write_ccf_set <= (k == 2);
		result_read <= (k == 4);
		@(posedge clk);
		{sequence_done, trigger_edge, result_write, result_write_ccf_set, result_read} <= 5'h0;
		@(posedge clk);
	endtask
	task automatic irq_chk(input logic exp);
		repeat (2) @(posedge clk);
		check("irq", {31'h0, exp}, {31'h0, irq});
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			complete_run();
		end
	end
	initial begin
		{psel, penable, pwrite, sequence_done, trigger_edge, result_write} = 6'h0;
		{result_write_ccf_set, result_read} = 2'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'hf;
		reset = 1'b1;
		rnd = 32'h45;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		rdchk("status reset", 8'h18, 32'h0);
		apb(8'h1c, 1'b0, 32'h0);
		check("unmapped", 32'h1, {31'h0, err});
		wr(8'h04, 32'h0);
		wr(8'h14, 32'h0);
		ev(1);
		ev(2);
		ev(0);
		rdchk("all flags", 8'h18, status_of(1, 1, 1, 1));
		wr(8'h18, 32'h0f);
		rdchk("zero write", 8'h18, status_of(1, 1, 1, 1));
		wr(8'h18, 32'h20);
		rdchk("clear trig", 8'h18, status_of(1, 0, 1, 1));
		wr(8'h18, 32'h10);
		rdchk("clear result", 8'h18, status_of(1, 0, 0, 1));
		wr(8'h18, 32'h80);
		rdchk("clear finished", 8'h18, status_of(0, 0, 0, 1));
		for (int i = 0; i < 7; i++) begin
			wr(8'h14, 32'h1);
			ev(1);
			ev(2);
			ev(0);
			rnd = xorshift(rnd);
			wr(i < 5 ? 8'(4 * i) : 8'(32 + 4 * (i - 5)), rnd & 32'hfe);
			rdchk("abort", 8'h18, status_of(1, 0, 0, 0));
		end
		wr(8'h14, 32'h1);
		rdchk("start clears", 8'h18, 32'h0);
		check("scan", 32'h1, {31'h0, scan_mode});
		ev(0);
		wr(8'h18, 32'h80);
		ev(0);
		rdchk("scan again", 8'h18, status_of(1, 0, 0, 0));
		check("running", 32'h1, {31'h0, sequence_running});
		pstrb <= 4'he;
		wr(8'h18, 32'h80);
		pstrb <= 4'hf;
		rdchk("strobe off", 8'h18, status_of(1, 0, 0, 0));
		for (int f = 0; f < 2; f++) begin
			wr(8'h08, f);
			wr(8'h14, 32'h0);
			ev(0);
			ev(4);
			rdchk("fast clear", 8'h18, status_of(f == 0, 0, 0, 0));
			check("fast clear bit", f, {31'h0, fast_clr});
		end
		wr(8'h08, 32'h0);
		wr(8'h04, 32'h1);
		wr(8'h14, 32'h0);
		ev(1);
		rdchk("level trig", 8'h18, 32'h0);
		check("level select", 32'h1, {31'h0, level_sel});
		wr(8'h04, 32'h0);
		for (int j = 0; j < 3; j++) begin
			rnd = xorshift(rnd);
			n = int'(rnd % 20) + 1;
			wr(8'h14, 32'h0);
			repeat (n) ev(3);
			rdchk("counter", 8'h18, status_of(0, 0, 0, n));
		end
		// earlier scenarios left interrupt status bits set
		wr(8'h28, 32'h7);
		wr(8'h2c, 32'h7);
		wr(8'h14, 32'h0);
		ev(0);
		irq_chk(1'b1);
		rdchk("irq status", 8'h28, 32'h1);
		wr(8'h2c, 32'h0);
		irq_chk(1'b0);
		wr(8'h2c, 32'h7);
		irq_chk(1'b1);
		wr(8'h28, 32'h1);
		irq_chk(1'b0);
		complete_run();
	end
endmodule
`default_nettype wire
